// ==== hw/csf_pkg.sv ====
// shared constants and types of the status flags and mode block
package csf_pkg;
  // ==========================================================
  // status_flags_word bit positions
  localparam int FL_CARRY = 0;
  localparam int FL_PARITY = 2;
  localparam int FL_HALF = 4;
  localparam int FL_ZERO = 6;
  localparam int FL_SIGN = 7;
  localparam int FL_STEP = 8;
  localparam int FL_INTEN = 9;
  localparam int FL_DIR = 10;
  localparam int FL_OVER = 11;
  localparam int FL_IO_PRIVILEGE_LEVEL = 12; // two bits, 13:12
  localparam int FL_RESUME = 16;
  localparam int FL_VLEG = 17;
  // machine_control_word bit positions
  localparam int CW_PROT = 0;
  localparam int CW_MON = 1;
  localparam int CW_STANDIN = 2;
  localparam int CW_TASKSW = 3;
  localparam int CW_PAGE = 31;
  // writable bits and values after reset
  localparam logic [31:0] FL_WMASK = 32'h0003_7fd5;
  localparam logic [31:0] CW_WMASK = 32'h8000_000f;
  localparam logic [31:0] FL_RESET = 32'h0000_0000;
  localparam logic [31:0] CW_RESET = 32'h0000_0000;
  localparam logic [31:0] IP_RESET_VAL = 32'h0000_0000;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_FLAGS16 = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_IP = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_GPR = 8'h20; // eight words
  localparam int ST_MODE = 8; // status word mode field
  // exception vectors
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_NOEXT = 8'h07;
  localparam logic [7:0] VEC_PROT = 8'h0d;
  // queue depth and string index registers
  localparam int PQ_BYTES = 16;
  localparam logic [2:0] IDX_SRC_IX = 3'h6;
  localparam logic [2:0] IDX_DST_IX = 3'h7;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_AND, OP_OR, OP_XOR, OP_CMP
  } csf_op_t;
  typedef enum logic [3:0] {
    CLS_NONE, CLS_ALU, CLS_STRING, CLS_WAIT, CLS_ESC, CLS_IO,
    CLS_PRIV, CLS_SETIF, CLS_CLRIF, CLS_SETDF, CLS_CLRDF, CLS_SHORT_STATUS_WORD_LOAD
  } csf_cls_t;
  typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32} csf_size_t;
  typedef enum logic [1:0] {PT_FULL, PT_LO16, PT_LO8, PT_HI8} csf_part_t;
  // one retiring decoded instruction
  typedef struct packed {
    logic valid;
    csf_cls_t cls;
    csf_op_t op;
    logic [2:0] dst;
    logic [2:0] src;
    logic hi8;
    logic byte_op;
    logic code32;
    logic size_pfx;
    logic use_imm;
    logic dbg_fault;
    logic [4:0] len;
    logic [31:0] imm;
  } csf_inst_t;
  typedef struct packed {
    logic exc_valid;
    logic [7:0] exc_vec;
    logic int_ack;
    logic io_check;
    logic underrun;
  } csf_event_t;
  typedef struct packed {
    logic prot;
    logic paging;
    logic vleg;
    logic real_seg;
    logic dir_down;
  } csf_mode_t;
  typedef struct packed {
    logic [31:0] result;
    logic cf;
    logic pf;
    logic af;
    logic zf;
    logic sf;
    logic of;
  } csf_alu_t;
endpackage : csf_pkg

// ==== hw/csf_core.sv ====
// status flags, control word, instruction pointer and operand logic
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// ==========================================================
// What this block does
// - carry flag bit 0 from top carry/borrow
// - parity bit 2 set on even low byte
// - half carry bit 4 from low nibble
// - zero flag bit 6 on zero result
// - sign flag bit 7 copies top bit
// - step flag traps after next instruction, clears
// - interrupts taken only with enable flag set
// - direction flag chooses string index step
// - overflow bit 11 on signed overflow
// - privilege field gates I/O in protected non-legacy mode, enable flag in legacy mode
// - resume flag suppresses next debug fault
// - legacy mode faults privileged opcodes, old segments
// - short load sets but never clears protection
// - monitor bit lets wait raise fault 7
// - stand-in bit makes coprocessor opcodes fault
// - task switched makes extension use fault
// - bit 31 enables paging unit
// - low 16 flag bits form default view
// - instruction pointer advances per instruction
// - sixteen byte prefetch queue feeds decoder
// - default operand size, prefix swaps it
// - eight registers split into 16/8 bit parts, high byte on four
module csf_core
  import csf_pkg::*;
#(
  parameter int PQ_DEPTH = PQ_BYTES, // prefetch queue bytes
  parameter logic [31:0] IP_RESET = IP_RESET_VAL // restart address
) (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN, // low freezes all state
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  input wire csf_inst_t INST_IN, // decoded instruction queue head
  input wire logic [1:0] CPL_IN, // current_privilege_level
  input wire logic INTR_PIN_IN, // maskable request pin
  input wire logic [31:0] HANDLER_ADDR_IN, // vectored handler
  input wire logic CODE_VALID_IN,
  input wire logic [7:0] CODE_BYTE_IN,
  output logic CODE_READY_OUT,
  output logic [7:0] PQ_HEAD_OUT,
  output logic [$clog2(PQ_DEPTH):0] PQ_LEVEL_OUT,
  output logic [31:0] FETCH_ADDR_OUT,
  output csf_event_t EVENT_OUT,
  output csf_mode_t MODE_OUT
);
  localparam int PW = $clog2(PQ_DEPTH);

  // all state of the block
  typedef struct packed {
    logic [31:0] flags; // status_flags_word
    logic [31:0] ctrl; // machine_control_word
    logic [31:0] ip; // instruction_pointer
    logic [7:0][31:0] gpr; // general registers
    logic [PQ_DEPTH-1:0][7:0] pq; // prefetch bytes
    logic [PW-1:0] pq_rd;
    logic [PW:0] pq_cnt;
    logic [7:0] head;
    logic rdy;
    logic [1:0] sync; // request pin synchroniser
    logic [31:0] rdata;
    csf_event_t ev;
    csf_mode_t mode;
  } csf_state_t;

  csf_state_t st_reg; // registered state
  csf_state_t st_next; // next state
  logic [1:0] rst_sync_reg; // reset release chain
  logic rst_n; // synchronised reset

  // ==========================================================
  // helper functions
  // register part picked by operand size
  function automatic csf_part_t part_of(input csf_size_t sz,
      input logic hi8, input logic [2:0] idx);
    if (sz == SZ_32) part_of = PT_FULL;
    else if (sz == SZ_16) part_of = PT_LO16;
    else if (hi8 && !idx[2]) part_of = PT_HI8;
    else part_of = PT_LO8;
  endfunction : part_of

  // read a register part, zero extended
  function automatic logic [31:0] rd_part(input logic [31:0] v,
      input csf_part_t p);
    case (p)
      PT_LO16: rd_part = {16'h0000, v[15:0]};
      PT_LO8: rd_part = {24'h00_0000, v[7:0]};
      PT_HI8: rd_part = {24'h00_0000, v[15:8]};
      default: rd_part = v;
    endcase
  endfunction : rd_part

  // merge a value into a register part
  function automatic logic [31:0] wr_part(input logic [31:0] old,
      input logic [31:0] v, input csf_part_t p);
    case (p)
      PT_LO16: wr_part = {old[31:16], v[15:0]};
      PT_LO8: wr_part = {old[31:8], v[7:0]};
      PT_HI8: wr_part = {old[31:16], v[7:0], old[7:0]};
      default: wr_part = v;
    endcase
  endfunction : wr_part

  // operands are shifted so their top bit sits at bit 31
  function automatic csf_alu_t alu(input csf_op_t op,
      input logic [31:0] a, input logic [31:0] b, input logic cin,
      input csf_size_t sz);
    csf_alu_t r;
    logic [4:0] sh;
    logic [32:0] as, bs, cs, rs;
    logic sub, arith;
    r = '0;
    sh = (sz == SZ_32) ? 5'h00 : (sz == SZ_16) ? 5'h10 : 5'h18;
    as = {1'h0, a << sh};
    bs = {1'h0, b << sh};
    cs = {1'h0, 32'h0000_0001 << sh}
      & {33{cin & (op == OP_ADC || op == OP_SBB)}};
    sub = (op == OP_SUB || op == OP_SBB || op == OP_CMP);
    arith = !(op == OP_AND || op == OP_OR || op == OP_XOR);
    case (op)
      OP_AND: rs = as & bs;
      OP_OR: rs = as | bs;
      OP_XOR: rs = as ^ bs;
      default: rs = sub ? as - bs - cs : as + bs + cs;
    endcase
    r.result = rs[31:0] >> sh;
    r.cf = arith & rs[32];
    r.pf = ~^r.result[7:0];
    r.af = arith & (a[4] ^ b[4] ^ r.result[4]);
    r.zf = (rs[31:0] == 32'h0000_0000);
    r.sf = rs[31];
    r.of = arith & (sub ? (as[31] != bs[31]) : (as[31] == bs[31]))
      & (rs[31] != as[31]);
    return r;
  endfunction : alu

  // ==========================================================
  // decode of the retiring instruction
  logic pe, vm, tf, ifl; // live mode bits
  logic [1:0] io_privilege_level;
  logic wide32; // wide operand is 32 bits
  csf_size_t sz;
  csf_part_t pd, ps;
  logic [31:0] opa, opb;
  csf_alu_t res;
  logic f13, f7, dbg_hit, pq_ok, commit, take_int, push;
  logic [31:0] step; // string index stride
  logic [PW-1:0] wr_idx;
  logic [PW:0] pop;

  assign pe = st_reg.ctrl[CW_PROT];
  assign vm = st_reg.flags[FL_VLEG] & pe;
  assign tf = st_reg.flags[FL_STEP];
  assign ifl = st_reg.flags[FL_INTEN];
  assign io_privilege_level = st_reg.flags[FL_IO_PRIVILEGE_LEVEL+1:FL_IO_PRIVILEGE_LEVEL];
  // 16-bit default in real or legacy code, prefix swaps it
  assign wide32 = (INST_IN.code32 & pe & ~vm) ^ INST_IN.size_pfx;
  assign sz = INST_IN.byte_op ? SZ_8 : wide32 ? SZ_32 : SZ_16;
  assign pd = part_of(sz, INST_IN.hi8, INST_IN.dst);
  assign ps = part_of(sz, INST_IN.use_imm ? 1'h0 : INST_IN.hi8,
    INST_IN.src);
  assign opa = rd_part(st_reg.gpr[INST_IN.dst], pd);
  assign opb = rd_part(INST_IN.use_imm ? INST_IN.imm
    : st_reg.gpr[INST_IN.src], ps);
  assign res = alu(INST_IN.op, opa, opb, st_reg.flags[FL_CARRY], sz);
  assign step = (sz == SZ_8) ? 32'h0000_0001
    : (sz == SZ_16) ? 32'h0000_0002 : 32'h0000_0004;
  // faults of the general protection class
  assign f13 = (INST_IN.cls == CLS_PRIV && vm)
    || ((INST_IN.cls == CLS_SETIF || INST_IN.cls == CLS_CLRIF)
    && vm && CPL_IN > io_privilege_level);
  // extension not present faults
  assign f7 = (INST_IN.cls == CLS_WAIT
    && st_reg.ctrl[CW_MON] && st_reg.ctrl[CW_TASKSW])
    || (INST_IN.cls == CLS_ESC && st_reg.ctrl[CW_STANDIN])
    || (INST_IN.cls == CLS_ESC && st_reg.ctrl[CW_TASKSW]);
  assign dbg_hit = INST_IN.dbg_fault & ~st_reg.flags[FL_RESUME];
  assign pq_ok = {1'h0, INST_IN.len} <= 6'(st_reg.pq_cnt);
  assign commit = CE_IN & INST_IN.valid & pq_ok & ~dbg_hit & ~f13
    & ~f7;
  assign take_int = commit & ~tf & st_reg.sync[1] & ifl;
  assign push = CODE_VALID_IN & st_reg.rdy;
  assign wr_idx = st_reg.pq_rd + st_reg.pq_cnt[PW-1:0];
  assign pop = commit ? (PW+1)'(INST_IN.len) : '0;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    if (CE_IN) begin
      st_next.ev = '0;
      st_next.rdata = 32'h0000_0000;
      st_next.sync = {st_reg.sync[0], INTR_PIN_IN};
      // retire or fault the instruction at the queue head
      if (INST_IN.valid) begin
        if (!pq_ok) begin
          st_next.ev.underrun = 1'h1; // not enough code bytes
        end else if (dbg_hit) begin
          st_next.ev.exc_valid = 1'h1;
          st_next.ev.exc_vec = VEC_DEBUG;
        end else if (f13) begin
          st_next.ev.exc_valid = 1'h1;
          st_next.ev.exc_vec = VEC_PROT;
        end else if (f7) begin
          st_next.ev.exc_valid = 1'h1;
          st_next.ev.exc_vec = VEC_NOEXT;
        end else begin
          st_next.ip = st_reg.ip + 32'(INST_IN.len);
          st_next.pq_rd = st_reg.pq_rd + PW'(INST_IN.len);
          st_next.flags[FL_RESUME] = 1'h0;
          case (INST_IN.cls)
            CLS_ALU: begin
              if (INST_IN.op != OP_CMP) begin
                st_next.gpr[INST_IN.dst] =
                  wr_part(st_reg.gpr[INST_IN.dst], res.result, pd);
              end
              st_next.flags[FL_CARRY] = res.cf;
              st_next.flags[FL_PARITY] = res.pf;
              st_next.flags[FL_HALF] = res.af;
              st_next.flags[FL_ZERO] = res.zf;
              st_next.flags[FL_SIGN] = res.sf;
              st_next.flags[FL_OVER] = res.of;
            end
            CLS_STRING: begin
              // index registers step down when direction is set
              if (st_reg.flags[FL_DIR]) begin
                st_next.gpr[IDX_SRC_IX] = st_reg.gpr[IDX_SRC_IX] - step;
                st_next.gpr[IDX_DST_IX] = st_reg.gpr[IDX_DST_IX] - step;
              end else begin
                st_next.gpr[IDX_SRC_IX] = st_reg.gpr[IDX_SRC_IX] + step;
                st_next.gpr[IDX_DST_IX] = st_reg.gpr[IDX_DST_IX] + step;
              end
            end
            CLS_IO: begin
              // above the privilege field the map must be consulted
              st_next.ev.io_check = pe & ~vm & (CPL_IN > io_privilege_level);
            end
            CLS_SETIF: st_next.flags[FL_INTEN] = 1'h1;
            CLS_CLRIF: st_next.flags[FL_INTEN] = 1'h0;
            CLS_SETDF: st_next.flags[FL_DIR] = 1'h1;
            CLS_CLRDF: st_next.flags[FL_DIR] = 1'h0;
            CLS_SHORT_STATUS_WORD_LOAD: begin
              // short load may set protection but never clear it
              st_next.ctrl[CW_PROT] = st_reg.ctrl[CW_PROT]
                | st_reg.gpr[INST_IN.src][0];
              st_next.ctrl[3:1] = st_reg.gpr[INST_IN.src][3:1];
            end
            default: begin
            end
          endcase
          // boundary events: step trap first, then interrupt
          if (tf) begin
            st_next.ev.exc_valid = 1'h1;
            st_next.ev.exc_vec = VEC_DEBUG;
            st_next.flags[FL_STEP] = 1'h0;
          end else if (take_int) begin
            st_next.ev.int_ack = 1'h1;
            st_next.ip = HANDLER_ADDR_IN;
          end
        end
      end
      // prefetch queue fill, slot beyond the last valid byte
      if (push) begin
        st_next.pq[wr_idx] = CODE_BYTE_IN;
      end
      st_next.pq_cnt = st_reg.pq_cnt - pop + (PW+1)'(push);
      st_next.rdy = st_next.pq_cnt != (PW+1)'(PQ_DEPTH);
      // software writes win over instruction effects
      if (REG_WR_IN) begin
        case (REG_ADDR_IN)
          OFS_FLAGS: st_next.flags = REG_WDATA_IN & FL_WMASK;
          OFS_FLAGS16: st_next.flags[15:0] =
            REG_WDATA_IN[15:0] & FL_WMASK[15:0];
          OFS_CTRL: st_next.ctrl = REG_WDATA_IN & CW_WMASK;
          OFS_IP: st_next.ip = REG_WDATA_IN;
          default: begin
            if (REG_ADDR_IN[7:5] == OFS_GPR[7:5]
                && REG_ADDR_IN[1:0] == 2'h0) begin
              st_next.gpr[REG_ADDR_IN[4:2]] = REG_WDATA_IN;
            end
          end
        endcase
      end
      // read data for the next cycle, zero when unmapped
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          OFS_FLAGS: st_next.rdata = st_reg.flags;
          OFS_FLAGS16: st_next.rdata = {16'h0000, st_reg.flags[15:0]};
          OFS_CTRL: st_next.rdata = st_reg.ctrl;
          OFS_IP: st_next.rdata = st_reg.ip;
          OFS_STATUS: st_next.rdata = 32'(st_reg.pq_cnt)
            | (32'(st_reg.mode) << ST_MODE);
          default: begin
            if (REG_ADDR_IN[7:5] == OFS_GPR[7:5]
                && REG_ADDR_IN[1:0] == 2'h0) begin
              st_next.rdata = st_reg.gpr[REG_ADDR_IN[4:2]];
            end
          end
        endcase
      end
      st_next.head = st_next.pq[st_next.pq_rd];
      // mode outputs follow the new control bits
      st_next.mode.prot = st_next.ctrl[CW_PROT];
      st_next.mode.paging = st_next.ctrl[CW_PAGE];
      st_next.mode.vleg = st_next.flags[FL_VLEG] & st_next.ctrl[CW_PROT];
      st_next.mode.real_seg = ~st_next.ctrl[CW_PROT]
        | st_next.flags[FL_VLEG];
      st_next.mode.dir_down = st_next.flags[FL_DIR];
    end
  end

  // ==========================================================
  // reset release chain
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'h1};
  end
  assign rst_n = rst_sync_reg[1];

  // state register
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.flags <= FL_RESET;
      st_reg.ctrl <= CW_RESET;
      st_reg.ip <= IP_RESET;
      st_reg.rdy <= 1'h1;
      st_reg.mode.real_seg <= 1'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA_OUT = st_reg.rdata;
  assign CODE_READY_OUT = st_reg.rdy;
  assign PQ_HEAD_OUT = st_reg.head;
  assign PQ_LEVEL_OUT = st_reg.pq_cnt;
  assign FETCH_ADDR_OUT = st_reg.ip;
  assign EVENT_OUT = st_reg.ev;
  assign MODE_OUT = st_reg.mode;

  // ==========================================================
  // checks on a plain 32-bit add, then on traps, faults, string steps, the instruction pointer and the queue
  logic chk_add; // add retiring with no register write beside
  logic [32:0] ref_sum;
  logic [4:0] ref_nib;
  logic ref_ovf, ref_zero, ref_par, dfl;
  logic [31:0] src_ix, ilen;
  assign chk_add = commit && INST_IN.cls == CLS_ALU
    && INST_IN.op == OP_ADD && sz == SZ_32 && !REG_WR_IN;
  assign ref_sum = {1'h0, opa} + {1'h0, opb};
  assign ref_nib = {1'h0, opa[3:0]} + {1'h0, opb[3:0]};
  assign ref_ovf = (opa[31] == opb[31]) && (ref_sum[31] != opa[31]);
  assign ref_zero = ref_sum[31:0] == 32'h0000_0000;
  assign ref_par = ~^ref_sum[7:0];
  assign dfl = st_reg.flags[FL_DIR];
  assign src_ix = st_reg.gpr[IDX_SRC_IX];
  assign ilen = 32'(INST_IN.len);

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!rst_n);

  carry_flag_a: assert property (
    chk_add |=> st_reg.flags[FL_CARRY] == $past(ref_sum[32]))
    else $error("carry flag wrong after add");
  parity_flag_a: assert property (
    chk_add |=> st_reg.flags[FL_PARITY] == $past(ref_par))
    else $error("parity flag wrong after add");
  half_carry_a: assert property (
    chk_add |=> st_reg.flags[FL_HALF] == $past(ref_nib[4]))
    else $error("half carry wrong after add");
  zero_flag_a: assert property (
    chk_add |=> st_reg.flags[FL_ZERO] == $past(ref_zero))
    else $error("zero flag wrong after add");
  sign_flag_a: assert property (
    chk_add |=> st_reg.flags[FL_SIGN] == $past(ref_sum[31]))
    else $error("sign flag wrong after add");
  over_flag_a: assert property (
    chk_add |=> st_reg.flags[FL_OVER] == $past(ref_ovf))
    else $error("overflow flag wrong after add");
  step_trap_a: assert property (
    commit && tf && !REG_WR_IN |=> EVENT_OUT.exc_valid
      && EVENT_OUT.exc_vec == VEC_DEBUG && !st_reg.flags[FL_STEP])
    else $error("single step trap missing");
  intr_gate_a: assert property (
    EVENT_OUT.int_ack |-> $past(ifl) && $past(commit))
    else $error("interrupt taken while disabled");
  string_dir_a: assert property (
    commit && INST_IN.cls == CLS_STRING && sz == SZ_8 && !REG_WR_IN
      |=> src_ix == ($past(dfl) ? $past(src_ix) - 32'h0000_0001
      : $past(src_ix) + 32'h0000_0001))
    else $error("string index stepped wrong way");
  legacy_fault_a: assert property (
    CE_IN && INST_IN.valid && pq_ok && !dbg_hit && vm
      && INST_IN.cls == CLS_PRIV && !REG_WR_IN
      |=> EVENT_OUT.exc_vec == VEC_PROT
      && FETCH_ADDR_OUT == $past(FETCH_ADDR_OUT))
    else $error("privileged opcode not faulted");
  msw_keep_a: assert property (
    commit && INST_IN.cls == CLS_SHORT_STATUS_WORD_LOAD && pe && !REG_WR_IN
      |=> MODE_OUT.prot)
    else $error("short load cleared protection");
  esc_fault_a: assert property (
    CE_IN && INST_IN.valid && pq_ok && !dbg_hit
      && INST_IN.cls == CLS_ESC && st_reg.ctrl[CW_STANDIN]
      |=> EVENT_OUT.exc_valid && EVENT_OUT.exc_vec == VEC_NOEXT)
    else $error("coprocessor opcode not faulted");
  ip_adv_a: assert property (
    commit && !take_int && !REG_WR_IN
      |=> FETCH_ADDR_OUT == $past(FETCH_ADDR_OUT) + $past(ilen))
    else $error("instruction pointer not advanced");
  pq_full_a: assert property (
    CODE_READY_OUT == (PQ_LEVEL_OUT != (PW+1)'(PQ_DEPTH)))
    else $error("queue ready disagrees with level");
endmodule : csf_core

// ==== bench/csf_core_bench.sv ====
// self-checking bench for the status flags and mode block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module csf_core_bench;
  import csf_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic clk, rstn, wr, rd, cv, intr, bop, dbg, pfx;
  logic [7:0] addr, cb, head;
  logic [1:0] current_privilege_level; // current privilege level driven into the block
  logic [31:0] wd, rdata, fa;
  logic [4:0] lvl;
  logic rdy;
  csf_inst_t inst;
  csf_event_t ev, evo;
  csf_mode_t mode;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  csf_core u_dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .INST_IN(inst), .CPL_IN(current_privilege_level),
    .INTR_PIN_IN(intr), .HANDLER_ADDR_IN(32'h0000_4000),
    .CODE_VALID_IN(cv), .CODE_BYTE_IN(cb), .CODE_READY_OUT(rdy),
    .PQ_HEAD_OUT(head), .PQ_LEVEL_OUT(lvl), .FETCH_ADDR_OUT(fa),
    .EVENT_OUT(evo), .MODE_OUT(mode));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end
  // register bus write, one strobe cycle
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // register bus read, data compared in the following cycle
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rreg
  // offer n code bytes back to back
  task automatic push(input int n);
    repeat (n) begin
      @(posedge clk);
      cv <= 1'b1; cb <= cb + 8'h01;
    end
    @(posedge clk);
    cv <= 1'b0;
  endtask : push
  // retire one instruction and capture its event pulse
  task automatic ret(input csf_cls_t c, input csf_op_t o,
                     input logic [2:0] d, input logic [4:0] ln);
    @(posedge clk);
    inst <= '{valid: 1'b1, cls: c, op: o, dst: d, src: d, hi8: 1'b0,
      byte_op: bop, code32: 1'b1, size_pfx: pfx, use_imm: 1'b1,
      dbg_fault: dbg, len: ln, imm: 32'h0000_0001};
    @(posedge clk);
    inst.valid <= 1'b0;
    #1 ev = evo;
  endtask : ret
  // print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ==========================================================
  // alu cases: operand, op, expected result and flags
  logic [31:0] ta [3] = '{32'hffff_ffff, 32'h7fff_ffff, 32'h0000_0000};
  csf_op_t to [3] = '{OP_ADD, OP_ADD, OP_SUB};
  logic [31:0] tr [3] = '{32'h0000_0000, 32'h8000_0000, 32'hffff_ffff};
  logic [31:0] tf [3] = '{32'h0000_0055, 32'h0000_0894, 32'h0000_0095};
  // coprocessor fault cases: control word and class
  logic [31:0] cw [3] = '{32'h0000_0005, 32'h0000_000b, 32'h0000_0009};
  csf_cls_t cc [3] = '{CLS_ESC, CLS_WAIT, CLS_ESC};
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; cv = 1'b0; intr = 1'b0;
    bop = 1'b0; addr = 8'h00; cb = 8'h00; wd = 32'h0; inst = '0;
    dbg = 1'b0; pfx = 1'b0; current_privilege_level = 2'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(OFS_CTRL, CW_RESET);
    #1 `CHK(mode.real_seg, 1'b1)
    // fill the queue until it refuses, then drain it
    push(18);
    #1 `CHK(lvl, 5'h10)
    `CHK(rdy, 1'b0)
    `CHK(head, 8'h01)
    ret(CLS_NONE, OP_ADD, 3'h0, 5'h10);
    #1 `CHK(lvl, 5'h00)
    rreg(OFS_IP, 32'h0000_0010);
    ret(CLS_NONE, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.underrun, 1'b1)
    $display("test queue done");
    wreg(OFS_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wreg(OFS_GPR, ta[i]);
      push(2);
      ret(CLS_ALU, to[i], 3'h0, 5'h02);
      rreg(OFS_GPR, tr[i]);
      rreg(OFS_FLAGS, tf[i]);
    end
    rreg(OFS_IP, 32'h0000_0016);
    $display("test alu done");
    wreg(OFS_FLAGS, 32'h0000_0200);
    intr <= 1'b1;
    push(2);
    ret(CLS_NONE, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.int_ack, 1'b1)
    `CHK(fa, 32'h0000_4000)
    rreg(OFS_IP, 32'h0000_4000);
    wreg(OFS_FLAGS, 32'h0000_0100);
    ret(CLS_NONE, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.int_ack, 1'b0)
    `CHK(ev.exc_vec, VEC_DEBUG)
    rreg(OFS_FLAGS, 32'h0000_0000);
    intr <= 1'b0;
    $display("test interrupt done");
    wreg(OFS_FLAGS, 32'h0000_0400);
    wreg(OFS_GPR + 8'h18, 32'h0000_0010);
    bop = 1'b1;
    push(1);
    ret(CLS_STRING, OP_ADD, 3'h0, 5'h01);
    bop = 1'b0;
    rreg(OFS_GPR + 8'h18, 32'h0000_000f);
    `CHK(mode.dir_down, 1'b1)
    push(1);
    for (int i = 0; i < 3; i++) begin
      wreg(OFS_CTRL, cw[i]);
      ret(cc[i], OP_ADD, 3'h0, 5'h01);
      `CHK(ev.exc_vec, VEC_NOEXT)
    end
    $display("test extension done");
    wreg(OFS_CTRL, 32'h0000_0001);
    wreg(OFS_GPR + 8'h04, 32'h0000_0000);
    ret(CLS_SHORT_STATUS_WORD_LOAD, OP_ADD, 3'h1, 5'h01);
    rreg(OFS_CTRL, 32'h0000_0001);
    wreg(OFS_CTRL, 32'h8000_0000);
    #1 `CHK(mode.paging, 1'b1)
    `CHK(mode.prot, 1'b0)
    wreg(OFS_FLAGS, 32'hffff_ffff);
    rreg(OFS_FLAGS, FL_WMASK);
    rreg(OFS_FLAGS16, 32'h0000_7fd5);
    rreg(8'h40, 32'h0000_0000);
    $display("test registers done");
    // legacy mode, privilege field, resume flag and operand size
    wreg(OFS_CTRL, 32'h0000_0001);
    wreg(OFS_FLAGS, 32'h0003_0000);
    #1 `CHK(mode.vleg, 1'b1)
    `CHK(mode.real_seg, 1'b1)
    intr <= 1'b1;
    current_privilege_level <= 2'h3;
    push(3);
    dbg = 1'b1;
    ret(CLS_NONE, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.exc_valid, 1'b0)
    `CHK(ev.int_ack, 1'b0)
    ret(CLS_NONE, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.exc_vec, VEC_DEBUG)
    dbg = 1'b0;
    ret(CLS_PRIV, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.exc_vec, VEC_PROT)
    ret(CLS_SETIF, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.exc_vec, VEC_PROT)
    wreg(OFS_FLAGS, 32'h0000_0000);
    ret(CLS_IO, OP_ADD, 3'h0, 5'h01);
    `CHK(ev.io_check, 1'b1)
    `CHK(ev.int_ack, 1'b0)
    wreg(OFS_GPR, 32'h1234_ffff);
    pfx = 1'b1;
    ret(CLS_ALU, OP_ADD, 3'h0, 5'h01);
    pfx = 1'b0;
    rreg(OFS_GPR, 32'h1234_0000);
    rreg(OFS_FLAGS, 32'h0000_0055);
    $display("test modes done");
    summarize();
  end
endmodule : csf_core_bench
